// *** logic/serial_option_loader_consts.vh ***
// constants for the serial option loader
`ifndef SERIAL_OPTION_LOADER_CONSTS_VH
`define SERIAL_OPTION_LOADER_CONSTS_VH
`define SET_WIDTH 39
`define OPT_LOW_BIT 25
`define OPT_HIGH_BIT 38
`define OPT_COUNT 14
`define FULL_COUNT 39
`define BIT_HORN_SELECT 38
`define BIT_EOL_ENABLE 37
`define BIT_LB_HUSH_ENABLE 36
`define BIT_HUSH_OPTION 35
`define BIT_DRIFT_ENABLE 34
`define BIT_TRIP_HI 33
`define BIT_TRIP_LO 31
`define FLD_CURRENT_HI 30
`define FLD_CURRENT_LO 29
`define FLD_INTEG_HI 28
`define FLD_INTEG_LO 27
`define FLD_GAIN_HI 26
`define FLD_GAIN_LO 25
`define FLD_NORMAL_HI 24
`define FLD_NORMAL_LO 20
`define FLD_HYST_HI 19
`define FLD_HYST_LO 15
`define FLD_HUSH_HI 14
`define FLD_HUSH_LO 10
`define FLD_CHAMBER_HI 9
`define FLD_CHAMBER_LO 5
`define FLD_DRIFT_HI 4
`define FLD_DRIFT_LO 0
`define STORE_PULSE_MS 10
`define CLK_HZ 10000000
`define STORE_PULSE_CYCLES ((`STORE_PULSE_MS * `CLK_HZ + 999) / 1000)
`define MODE_STEPS_W 4
`define MODE_OPTION 4'h0
`define MODE_FULL 4'h6
`endif

// *** logic/pin_sync.v ***
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire core_clk, // core clock
   input wire rst, // async reset, active high
   input wire pin_in, // asynchronous pin
   output reg level, // synchronised level
   output wire rise, // one-cycle rising pulse
   output wire fall // one-cycle falling pulse
);
   reg meta; // first stage, read only by level
   reg prev; // previous synchronised level
   // two flops, then one more for edge detection
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         level <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin_in;
         level <= meta;
         prev <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule
`default_nettype wire

// *** logic/serial_option_loader.v ***
// serial loader for option and calibration settings
//
// Functional notes
// R1: load options serially, data pin plus shift clock
// R2: committed bits persist as working configuration
// R3: programmer holds all pins low at power-up
// R4: enable pin rises, stays high throughout sequence
// R5: option mode loads bits 25 to 38 only
// R6: full serial mode loads bits 0 to 38
// R7: settings register field layout from bit 38
// R8: horn select one temporal, zero continuous
// R9: programmer presents data, pulses clock per bit
// R10: store pulse of 10 ms commits shift register
// R11: button swing to boost counts one mode step
// R12: option bits shifted 25 first, 38 last
// R13: sample data on rising shift clock edge
`include "serial_option_loader_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_option_loader #(
   parameter STORE_MIN_CYCLES = `STORE_PULSE_CYCLES // core cycles the store pin must stay high
) (
   input wire core_clk, // core clock, 10 MHz
   input wire rst, // power-on reset, active high
   input wire program_mode_pin, // programming enable pin
   input wire button_data_pin, // button pin, data level
   input wire button_boost_pin, // button pin at boost level, mode clock
   input wire shift_clock_pin, // serial shift clock
   input wire interconnect_pin, // store strobe during programming
   output reg [38:0] config_calibration_settings, // committed settings
   output reg horn_temporal, // 1 temporal, 0 continuous horn
   output reg end_of_life_enable, // end-of-life check on
   output reg low_battery_hush_enable, // low battery hush on
   output reg hush_option, // hush cancel option
   output reg drift_enable, // long-term drift on
   output reg [2:0] battery_trip_select, // battery trip point
   output reg [1:0] emitter_current_select, // emitter current
   output reg [1:0] integration_time_select, // integration time
   output reg [1:0] amplifier_gain_select, // amplifier gain
   output reg [4:0] normal_threshold, // normal limit
   output reg [4:0] hysteresis_threshold, // hysteresis limit
   output reg [4:0] reduced_sensitivity_threshold, // hush limit
   output reg [4:0] chamber_check_threshold, // chamber limit
   output reg [4:0] drift_baseline, // drift sample
   output reg [3:0] test_mode, // current mode step
   output reg store_done // pulses for one cycle, in the same cycle as a commit
);
   wire prog_level; // synchronised enable
   wire prog_rise; // enable edge
   wire data_level; // synchronised data
   wire boost_rise; // mode step edge
   wire sclk_rise; // shift clock edge
   wire ic_level; // synchronised store pin
   wire ic_fall; // store pin falling
   // raw pins gathered for the synchroniser loop:
   // 0 enable, 1 data, 2 boost, 3 shift clock, 4 store strobe
   wire [4:0] pin_vec; // raw asynchronous pins
   wire [4:0] sync_level; // levels after two flops
   wire [4:0] sync_rise; // one-cycle rising pulses
   wire [4:0] sync_fall; // one-cycle falling pulses
   genvar g; // synchroniser index
   reg [38:0] shift_reg; // staging shift register
   reg [5:0] bit_count; // bits taken in this mode
   reg [31:0] ic_high_cycles; // length of store pulse so far
   reg ic_long; // store pulse met minimum width
   reg armed; // session entered through enable rise
   wire option_mode; // option load selected
   wire full_mode; // full read/write selected
   wire [5:0] limit; // bits allowed in this mode

   assign pin_vec = {interconnect_pin, shift_clock_pin, button_boost_pin, button_data_pin, program_mode_pin};

   // one synchroniser per pin; data and shift clock share the same
   // two-flop delay, so a data bit and its clock edge stay aligned
   generate
      for (g = 0; g < 5; g = g + 1) begin : gen_sync
         pin_sync u_sync (
            .core_clk(core_clk), // shared clock
            .rst(rst), // shared reset
            .pin_in(pin_vec[g]), // raw pin
            .level(sync_level[g]), // settled level
            .rise(sync_rise[g]), // rising pulse
            .fall(sync_fall[g]) // falling pulse
         );
      end
   endgenerate

   // named views of the synchronised pins
   assign prog_level = sync_level[0];
   assign prog_rise = sync_rise[0];
   assign data_level = sync_level[1];
   assign boost_rise = sync_rise[2];
   assign sclk_rise = sync_rise[3];
   assign ic_level = sync_level[4];
   assign ic_fall = sync_fall[4];

   // mode decode and the bit budget of each loading mode
   assign option_mode = (test_mode == `MODE_OPTION);
   assign full_mode = (test_mode == `MODE_FULL);
   assign limit = option_mode ? 6'd`OPT_COUNT : 6'd`FULL_COUNT;

   // session arming and mode step counter
   // a session only opens on an enable rise, and since the synchroniser resets low, an enable pin
   // that is already high when reset ends still gives that rise and arms the loader
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         armed <= 1'b0;
         test_mode <= `MODE_OPTION;
      end else if (!prog_level) begin
         armed <= 1'b0; // R4
         test_mode <= `MODE_OPTION;
      end else begin
         if (prog_rise) begin
            armed <= 1'b1; // R4
         end
         // each swing to boost level is one mode step
         if (armed && boost_rise) begin
            test_mode <= test_mode + 4'h1; // R11
         end
      end
   end

   // serial shift-in on rising shift clock
   // extra clocks past the mode's bit count are dropped, and any
   // boost swing restarts the count for the newly selected mode
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_reg <= 39'h0;
         bit_count <= 6'h0;
      end else if (!prog_level) begin
         bit_count <= 6'h0; // R4
      end else if (boost_rise) begin
         bit_count <= 6'h0; // new mode restarts the count
      end else if (armed && sclk_rise && (option_mode || full_mode) && bit_count < limit) begin // R1 R13
         bit_count <= bit_count + 6'h1;
         if (option_mode) begin
            // first bit lands at 25 after all shifts, last at 38
            shift_reg[38:25] <= {data_level, shift_reg[38:26]}; // R5 R12
         end else begin
            // full mode walks the whole register, first bit ends at 0
            shift_reg <= {data_level, shift_reg[38:1]}; // R6
         end
      end
   end

   // store pulse width measurement
   // counts only while the pin is high; the flag survives the falling
   // edge through the cycle in which the commit looks at it and the one after
   // the count stops at the minimum width, so long pulses cannot wrap
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ic_high_cycles <= 32'h0;
         ic_long <= 1'b0;
      end else if (ic_level && prog_level) begin
         if (ic_high_cycles >= STORE_MIN_CYCLES - 1) begin
            ic_long <= 1'b1; // R10
         end else begin
            ic_high_cycles <= ic_high_cycles + 32'h1;
         end
      end else if (!ic_level) begin
         ic_high_cycles <= 32'h0;
         ic_long <= ic_long & ic_fall;
      end
   end

   // commit shift register into nonvolatile copy
   // only modes 0 and 6 carry serial data; a store strobe in any
   // other mode leaves the committed copy as it was
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         config_calibration_settings <= 39'h0;
         store_done <= 1'b0;
      end else begin
         store_done <= 1'b0;
         if (armed && prog_level && ic_fall && ic_long && (option_mode || full_mode)) begin
            if (option_mode) begin
               config_calibration_settings[38:25] <= shift_reg[38:25]; // R5 R10
            end else begin
               config_calibration_settings <= shift_reg; // R6 R10
            end
            store_done <= 1'b1; // R2
         end
      end
   end

   // decode working fields from committed settings
   // one register stage, so the fields trail the settings by a cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         horn_temporal <= 1'b0;
         end_of_life_enable <= 1'b0;
         low_battery_hush_enable <= 1'b0;
         hush_option <= 1'b0;
         drift_enable <= 1'b0;
         battery_trip_select <= 3'h0;
         emitter_current_select <= 2'h0;
         integration_time_select <= 2'h0;
         amplifier_gain_select <= 2'h0;
         normal_threshold <= 5'h0;
         hysteresis_threshold <= 5'h0;
         reduced_sensitivity_threshold <= 5'h0;
         chamber_check_threshold <= 5'h0;
         drift_baseline <= 5'h0;
      end else begin
         horn_temporal <= config_calibration_settings[`BIT_HORN_SELECT]; // R8
         end_of_life_enable <= config_calibration_settings[`BIT_EOL_ENABLE]; // R7
         low_battery_hush_enable <= config_calibration_settings[`BIT_LB_HUSH_ENABLE];
         hush_option <= config_calibration_settings[`BIT_HUSH_OPTION];
         drift_enable <= config_calibration_settings[`BIT_DRIFT_ENABLE];
         battery_trip_select <= config_calibration_settings[`BIT_TRIP_HI:`BIT_TRIP_LO]; // R7
         emitter_current_select <= config_calibration_settings[`FLD_CURRENT_HI:`FLD_CURRENT_LO];
         integration_time_select <= config_calibration_settings[`FLD_INTEG_HI:`FLD_INTEG_LO];
         amplifier_gain_select <= config_calibration_settings[`FLD_GAIN_HI:`FLD_GAIN_LO];
         normal_threshold <= config_calibration_settings[`FLD_NORMAL_HI:`FLD_NORMAL_LO];
         hysteresis_threshold <= config_calibration_settings[`FLD_HYST_HI:`FLD_HYST_LO];
         reduced_sensitivity_threshold <= config_calibration_settings[`FLD_HUSH_HI:`FLD_HUSH_LO];
         chamber_check_threshold <= config_calibration_settings[`FLD_CHAMBER_HI:`FLD_CHAMBER_LO];
         drift_baseline <= config_calibration_settings[`FLD_DRIFT_HI:`FLD_DRIFT_LO];
      end
   end
endmodule
`default_nettype wire

// *** verification/serial_option_loader_sva.sv ***
// checker for the serial option loader ports
`timescale 1ns/1ps
`default_nettype none
module serial_option_loader_sva (
   input wire logic core_clk, // core clock
   input wire logic rst, // async reset
   input wire logic program_mode_pin, // enable pin
   input wire logic [38:0] config_calibration_settings, // settings
   input wire logic horn_temporal, // horn select
   input wire logic [3:0] test_mode, // mode step
   input wire logic store_done // commit pulse
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_done_single: assert property (store_done |=> !store_done)
      else $error("commit pulse too long");
   chk_horn_follow: assert property (1'b1 |=> horn_temporal == $past(config_calibration_settings[38]))
      else $error("horn select stale");
   chk_commit_flag: assert property ($changed(config_calibration_settings) |-> store_done)
      else $error("settings changed without commit");
   chk_lower_kept: assert property (store_done && test_mode == 4'h0 |->
      $stable(config_calibration_settings[24:0]))
      else $error("lower bits disturbed");
   chk_mode_clear: assert property (!program_mode_pin [*4] |-> test_mode == 4'h0)
      else $error("mode kept with enable low");
   chk_idle_commit: assert property (!program_mode_pin [*6] |-> !store_done)
      else $error("commit with enable low");
   chk_mode_step: assert property ($changed(test_mode) |->
      test_mode == $past(test_mode) + 4'h1 || test_mode == 4'h0)
      else $error("mode jumped");
   chk_store_mode: assert property (store_done |-> $past(test_mode) == 4'h0 || $past(test_mode) == 4'h6)
      else $error("commit in wrong mode");
endmodule
bind serial_option_loader serial_option_loader_sva u_sva (.core_clk(core_clk), .rst(rst),
   .program_mode_pin(program_mode_pin), .config_calibration_settings(config_calibration_settings),
   .horn_temporal(horn_temporal), .test_mode(test_mode), .store_done(store_done));
`default_nettype wire

// *** verification/prog_fixture.sv ***
// programming fixture model driving the loader test pins
`timescale 1ns/1ps
`default_nettype none
module prog_fixture (
   input wire logic core_clk, // pacing clock
   output logic enable, // programming enable
   output logic data, // button data level
   output logic boost, // button at boost level
   output logic sclk, // shift clock
   output logic store // store strobe
);
   // all pins low at power-up
   initial begin
      {enable, data, boost, sclk, store} = 5'h00;
   end
   // wait on falling edges
   task automatic gap(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // re-enter programming and step the mode
   task automatic open_mode(input int steps);
      enable = 1'b0;
      gap(8);
      enable = 1'b1;
      gap(8);
      repeat (steps) begin
         boost = 1'b1;
         gap(8);
         boost = 1'b0;
         gap(8);
      end
   endtask
   // shift n bits, lowest first, 800 ns clock
   task automatic shift(input logic [39:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         data = v[i];
         gap(3);
         sclk = 1'b1;
         gap(4);
         sclk = 1'b0;
         data = ~v[i]; // line no longer valid
         gap(1);
      end
   endtask
   // store strobe of len cycles
   task automatic pulse(input int len);
      store = 1'b1;
      gap(len);
      store = 1'b0;
      gap(2);
   endtask
endmodule
`default_nettype wire

// *** verification/serial_option_loader_tb_top.sv ***
// self-checking bench for the serial option loader
`timescale 1ns/1ps
`default_nettype none
module serial_option_loader_tb_top;
   logic core_clk = 1'b0; // core clock
   logic rst = 1'b1; // reset
   localparam int STORE_N = 1000; // shortened store width for the run
   wire [38:0] cfg, fld; // settings and decoded fields
   wire [3:0] test_mode; // mode step
   wire store_done; // commit pulse
   logic seen; // commit seen flag
   wire en, dat, bst, sck, sto; // fixture pins
   int err_count = 0;
   int n_tests = 0;
   always #50 core_clk = ~core_clk;
   prog_fixture u_prog (.core_clk(core_clk), .enable(en), .data(dat), .boost(bst), .sclk(sck), .store(sto));
   serial_option_loader #(.STORE_MIN_CYCLES(STORE_N)) u_dut (.core_clk(core_clk), .rst(rst),
      .program_mode_pin(en), .button_data_pin(dat),
      .button_boost_pin(bst), .shift_clock_pin(sck), .interconnect_pin(sto), .config_calibration_settings(cfg),
      .horn_temporal(fld[38]), .end_of_life_enable(fld[37]), .low_battery_hush_enable(fld[36]),
      .hush_option(fld[35]), .drift_enable(fld[34]), .battery_trip_select(fld[33:31]),
      .emitter_current_select(fld[30:29]), .integration_time_select(fld[28:27]),
      .amplifier_gain_select(fld[26:25]), .normal_threshold(fld[24:20]), .hysteresis_threshold(fld[19:15]),
      .reduced_sensitivity_threshold(fld[14:10]), .chamber_check_threshold(fld[9:5]),
      .drift_baseline(fld[4:0]), .test_mode(test_mode), .store_done(store_done));
   // compare and count
   task automatic check(input string what, input logic [38:0] exp, input logic [38:0] got);
      n_tests++;
      if (exp !== got) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // option load keeps the lower bits
   function automatic logic [38:0] exp_opt(input logic [38:0] prev, input logic [13:0] b);
      return {b, prev[24:0]};
   endfunction
   // look for a commit within 20 cycles
   task automatic wait_done();
      seen = 1'b0;
      repeat (20) begin
         @(negedge core_clk);
         if (store_done === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      logic [38:0] full; // random full-mode settings
      logic [38:0] opt_exp; // settings expected after the option load
      full = 39'($urandom(30));
      full = {7'($urandom), 32'($urandom)};
      opt_exp = exp_opt(full, 14'h2118);
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      u_prog.open_mode(6);
      check("mode", 39'h6, {35'h0, test_mode});
      u_prog.shift({1'b0, full}, 39);
      u_prog.pulse(STORE_N - 1);
      wait_done();
      check("short store", 39'h0, {38'h0, seen});
      u_prog.pulse(STORE_N);
      wait_done();
      check("full store", 39'h1, {38'h0, seen});
      check("full load", full, cfg);
      check("fields", full, fld);
      $display("test full serial done");
      u_prog.open_mode(0);
      check("mode", 39'h0, {35'h0, test_mode});
      u_prog.shift({24'h0, 2'($urandom), 14'h2118}, 16);
      u_prog.pulse(STORE_N);
      wait_done();
      check("option store", 39'h1, {38'h0, seen});
      check("option load", opt_exp, cfg);
      check("horn", 39'h1, {38'h0, fld[38]});
      $display("test option load done");
      u_prog.open_mode(3);
      check("mode", 39'h3, {35'h0, test_mode});
      u_prog.shift({26'h0, 14'($urandom)}, 14);
      u_prog.pulse(STORE_N);
      wait_done();
      check("other mode store", 39'h0, {38'h0, seen});
      check("settings kept", opt_exp, cfg);
      $display("test refused store done");
      end_sim();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("watchdog expired");
      end_sim();
   end
endmodule
`default_nettype wire
